//--- dthr_pkg.sv
// constants shared by the dual-tone host register interface
// assumes a 10 MHz system clock and a 32-bit axi4-lite register bus
package dthr_pkg;
   // clock
   localparam int unsigned CLK_HZ = 10_000_000;
   // register byte offsets: low address = data, high address = control/status
   localparam logic [3:0] DATA_OFFS = 4'h0;
   localparam logic [3:0] CTRL_OFFS = 4'h4;
   // first control register fields
   localparam int CRA_TONE_OUT_BIT = 0;
   localparam int CRA_CALL_PROG_BIT = 1;
   localparam int CRA_IRQ_EN_BIT = 2;
   localparam int CRA_BANK_PTR_BIT = 3;
   // second control register fields
   localparam int CRB_BURST_BIT = 0;
   localparam int CRB_TEST_BIT = 1;
   localparam int CRB_SINGLE_BIT = 2;
   localparam int CRB_COLUMN_BIT = 3;
   // status register fields
   localparam int STAT_RX_IRQ_BIT = 0;
   localparam int STAT_TX_READY_BIT = 1;
   localparam int STAT_RX_VALID_BIT = 2;
   localparam int STAT_STEER_N_BIT = 3;
   // reset values
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic [3:0] CODE_RST = 4'h0;
   // guard times and burst timing
   localparam int unsigned GUARD_PRESENT_US = 40;
   localparam int unsigned GUARD_ABSENT_US = 40;
   localparam int unsigned BURST_MS = 51;
   localparam int unsigned GUARD_PRESENT_CYC = GUARD_PRESENT_US * (CLK_HZ / 1_000_000);
   localparam int unsigned GUARD_ABSENT_CYC = GUARD_ABSENT_US * (CLK_HZ / 1_000_000);
   localparam int unsigned BURST_CYC = BURST_MS * (CLK_HZ / 1000);
   // tone frequencies in tenths of a hertz, low group then high group
   localparam int unsigned TONE_DHZ [8] = '{6991, 7662, 8474, 9480,
                                            12159, 13317, 14719, 16450};
   localparam int unsigned SEGMENTS = 32;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // transmit burst sequencer
   typedef enum logic [1:0] {BURST_IDLE, BURST_TONE, BURST_PAUSE} dthr_burst_t;
endpackage

//--- dthr_regs.sv
// dual-tone transceiver host registers: receive latch with guard timing,
// transmit tone dividers with burst timing, shared control address, status.
// assumes a tone detector that gives a present level and a 4-bit code,
// synchronous to clk_i, and an external pull-up on the interrupt pin.
`timescale 1ns/1ns
module dthr_regs
   import dthr_pkg::*;
#(
   parameter int unsigned GUARD_PRESENT = GUARD_PRESENT_CYC,
   parameter int unsigned GUARD_ABSENT = GUARD_ABSENT_CYC,
   parameter int unsigned BURST_LEN = BURST_CYC,
   parameter int CNT_W = 22
) (
   input wire logic clk_i,                 // 10 MHz system clock
   input wire logic sys_rst_i,             // synchronous reset, active high
   // axi4-lite slave
   input wire logic [3:0] s_axi_awaddr,    // write address
   input wire logic s_axi_awvalid,         // write address valid
   output logic s_axi_awready,             // write address ready
   input wire logic [31:0] s_axi_wdata,    // write data
   input wire logic [3:0] s_axi_wstrb,     // write strobes
   input wire logic s_axi_wvalid,          // write data valid
   output logic s_axi_wready,              // write data ready
   output logic [1:0] s_axi_bresp,         // write response
   output logic s_axi_bvalid,              // write response valid
   input wire logic s_axi_bready,          // write response ready
   input wire logic [3:0] s_axi_araddr,    // read address
   input wire logic s_axi_arvalid,         // read address valid
   output logic s_axi_arready,             // read address ready
   output logic [31:0] s_axi_rdata,        // read data
   output logic [1:0] s_axi_rresp,         // read response
   output logic s_axi_rvalid,              // read data valid
   input wire logic s_axi_rready,          // read data ready
   // receiver side
   input wire logic tone_present_i,        // detector sees valid tone frequencies
   input wire logic [3:0] tone_code_i,     // detector code for the present pair
   input wire logic call_prog_i,           // hard-limited call progress tone
   output logic early_detect_out_o,        // raw tone presence, tone-pair mode only
   output logic steer_guard_pin_o,         // delayed steering level
   // interrupt pin, open drain
   output logic interrupt_tone_pin_o,      // pin output value, always low
   output logic interrupt_tone_pin_oe_o,   // high while pulling pin low
   // transmitter side
   output logic tone_on_o,                 // tone output enabled
   output logic [4:0] low_phase_o,         // low group sine segment index
   output logic [4:0] high_phase_o,        // high group sine segment index
   output logic [3:0] ctrl_second_o        // second control register contents
);

   // divider reload for one tone index, rounded to nearest cycle
   function automatic logic [15:0] seg_div(input logic [2:0] idx);
      int unsigned f;
      f = TONE_DHZ[idx];
      seg_div = 16'((CLK_HZ * 10 + f * SEGMENTS / 2) / (f * SEGMENTS));
   endfunction

   // transmit code to row index and column index
   function automatic logic [3:0] code_rowcol(input logic [3:0] c);
      logic [1:0] row;
      logic [1:0] col;
      row = 2'h3;
      col = 2'h3;
      unique case (c)
         4'h1, 4'h2, 4'h3: begin
            row = 2'h0;
            col = 2'(c - 4'h1);
         end
         4'h4, 4'h5, 4'h6: begin
            row = 2'h1;
            col = 2'(c - 4'h4);
         end
         4'h7: begin
            row = 2'h2;
            col = 2'h0;
         end
         4'h8, 4'h9: begin
            row = 2'h2;
            col = 2'(c - 4'h7);
         end
         4'hA: col = 2'h1;
         4'hB: col = 2'h0;
         4'hC: col = 2'h2;
         4'hD, 4'hE, 4'hF: begin
            row = 2'(c - 4'hD);
            col = 2'h3;
         end
         4'h0: begin
            row = 2'h3;
            col = 2'h3;
         end
      endcase
      code_rowcol = {row, col};
   endfunction

   logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;
   logic aw_full_reg, w_full_reg;
   logic [3:0] awaddr_reg;
   logic [3:0] wdata_reg;
   logic wstrb_reg;
   logic [3:0] ctrl_first_reg, ctrl_second_reg, tx_code_reg, rx_code_reg;
   logic bank_pointer_bit_reg;
   logic steer_reg, early_reg, rx_valid_reg, rx_irq_reg, tx_ready_reg, tx_irq_reg;
   logic [CNT_W-1:0] guard_cnt_reg, burst_cnt_reg;
   dthr_burst_t burst_state_reg;
   logic tone_on_reg, irq_oe_reg;
   logic [15:0] low_div_reg, high_div_reg;
   logic [4:0] low_phase_reg, high_phase_reg;

   logic do_write, data_wr, ctrl_wr, stat_rd, rx_latch, burst_done, tone_mode;
   logic ar_take;
   logic [3:0] tx_rowcol;
   assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
   assign data_wr = do_write && wstrb_reg && awaddr_reg == DATA_OFFS;
   assign ctrl_wr = do_write && wstrb_reg && awaddr_reg == CTRL_OFFS;
   assign ar_take = s_axi_arvalid && arready_reg;
   assign stat_rd = ar_take && s_axi_araddr == CTRL_OFFS;
   // tone-pair mode: call progress bit low
   assign tone_mode = !ctrl_first_reg[CRA_CALL_PROG_BIT];

   // write address and data capture, either order
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         awaddr_reg <= 4'h0;
         wdata_reg <= 4'h0;
         wstrb_reg <= 1'b0;
      end else begin
         if (s_axi_awvalid && awready_reg) begin
            awready_reg <= 1'b0;
            aw_full_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end else if (do_write) begin
            aw_full_reg <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            awready_reg <= 1'b1;
         end
         if (s_axi_wvalid && wready_reg) begin
            wready_reg <= 1'b0;
            w_full_reg <= 1'b1;
            wdata_reg <= s_axi_wdata[3:0];
            wstrb_reg <= s_axi_wstrb[0];
         end else if (do_write) begin
            w_full_reg <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            wready_reg <= 1'b1;
         end
      end
   end

   // write response, unmapped offsets answer slave error
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= (awaddr_reg == DATA_OFFS || awaddr_reg == CTRL_OFFS) ?
                      RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // read channel: low offset gives receive code, high offset gives status
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= 32'h0;
      end else if (ar_take) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= 32'h0;
         if (s_axi_araddr == DATA_OFFS) begin
            rdata_reg[3:0] <= rx_code_reg;
         end else if (s_axi_araddr == CTRL_OFFS) begin
            rdata_reg[STAT_RX_IRQ_BIT] <= rx_irq_reg;
            rdata_reg[STAT_TX_READY_BIT] <= tx_ready_reg;
            rdata_reg[STAT_RX_VALID_BIT] <= rx_valid_reg;
            rdata_reg[STAT_STEER_N_BIT] <= !steer_reg;
         end else begin
            rresp_reg <= RESP_SLVERR;
         end
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
         arready_reg <= 1'b1;
      end
   end

   // shared control address: pointer steers exactly one write to the second
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ctrl_first_reg <= CTRL_RST;
         ctrl_second_reg <= CTRL_RST;
         bank_pointer_bit_reg <= 1'b0;
      end else if (ctrl_wr) begin
         if (bank_pointer_bit_reg) begin
            ctrl_second_reg <= wdata_reg;
            bank_pointer_bit_reg <= 1'b0;
         end else begin
            ctrl_first_reg <= wdata_reg;
            bank_pointer_bit_reg <= wdata_reg[CRA_BANK_PTR_BIT];
         end
      end
   end

   // transmit code, write-only, read address returns receive code instead
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         tx_code_reg <= CODE_RST;
      end else if (data_wr) begin
         tx_code_reg <= wdata_reg;
      end
   end

   // guard timing: presence then absence must persist before steering changes
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         steer_reg <= 1'b0;
         early_reg <= 1'b0;
         guard_cnt_reg <= '0;
         rx_code_reg <= CODE_RST;
      end else begin
         early_reg <= tone_present_i && tone_mode;
         if (!tone_mode) begin
            guard_cnt_reg <= '0;
            steer_reg <= 1'b0;
         end else if (steer_reg == tone_present_i) begin
            guard_cnt_reg <= '0;
         end else if (!steer_reg && guard_cnt_reg >= CNT_W'(GUARD_PRESENT - 1)) begin
            guard_cnt_reg <= '0;
            steer_reg <= 1'b1;
            rx_code_reg <= tone_code_i;
         end else if (steer_reg && guard_cnt_reg >= CNT_W'(GUARD_ABSENT - 1)) begin
            guard_cnt_reg <= '0;
            steer_reg <= 1'b0;
         end else begin
            guard_cnt_reg <= guard_cnt_reg + 1'b1;
         end
      end
   end
   assign rx_latch = tone_mode && !steer_reg && tone_present_i &&
                     guard_cnt_reg >= CNT_W'(GUARD_PRESENT - 1);

   // sticky receive flags, new data wins over a clearing status read
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rx_valid_reg <= 1'b0;
         rx_irq_reg <= 1'b0;
      end else if (rx_latch) begin
         rx_valid_reg <= 1'b1;
         rx_irq_reg <= 1'b1;
      end else if (stat_rd) begin
         rx_valid_reg <= 1'b0;
         rx_irq_reg <= 1'b0;
      end
   end

   // burst sequencer: tone then pause of equal length, doubled in call progress
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         burst_state_reg <= BURST_IDLE;
         burst_cnt_reg <= '0;
      end else begin
         unique case (burst_state_reg)
            BURST_IDLE: begin
               burst_cnt_reg <= '0;
               if (data_wr && ctrl_second_reg[CRB_BURST_BIT]) begin
                  burst_state_reg <= BURST_TONE;
               end
            end
            BURST_TONE, BURST_PAUSE: begin
               if (burst_cnt_reg >= (tone_mode ? CNT_W'(BURST_LEN - 1) :
                                     CNT_W'(2 * BURST_LEN - 1))) begin
                  burst_cnt_reg <= '0;
                  burst_state_reg <= (burst_state_reg == BURST_TONE) ?
                                     BURST_PAUSE : BURST_IDLE;
               end else begin
                  burst_cnt_reg <= burst_cnt_reg + 1'b1;
               end
            end
         endcase
      end
   end
   assign burst_done = burst_state_reg == BURST_PAUSE &&
                       burst_cnt_reg >= (tone_mode ? CNT_W'(BURST_LEN - 1) :
                                         CNT_W'(2 * BURST_LEN - 1));

   // transmitter ready flags, set wins over clear
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         tx_ready_reg <= 1'b0;
         tx_irq_reg <= 1'b0;
      end else if (burst_done) begin
         tx_ready_reg <= 1'b1;
         tx_irq_reg <= 1'b1;
      end else if (stat_rd || data_wr) begin
         tx_ready_reg <= 1'b0;
         tx_irq_reg <= 1'b0;
      end
   end

   // open-drain pin: pulls low on pending events, or follows call progress tone
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         irq_oe_reg <= 1'b0;
      end else if (!ctrl_first_reg[CRA_IRQ_EN_BIT]) begin
         irq_oe_reg <= 1'b0;
      end else if (tone_mode) begin
         irq_oe_reg <= rx_irq_reg || (tx_irq_reg && ctrl_second_reg[CRB_BURST_BIT]);
      end else begin
         irq_oe_reg <= !call_prog_i;
      end
   end

   // tone enable from tone-out bit, gated by burst phase when bursting
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         tone_on_reg <= 1'b0;
      end else begin
         tone_on_reg <= ctrl_first_reg[CRA_TONE_OUT_BIT] &&
                        (!ctrl_second_reg[CRB_BURST_BIT] || burst_state_reg == BURST_TONE);
      end
   end

   // segment dividers for both groups, 32 segments per tone period
   assign tx_rowcol = code_rowcol(tx_code_reg);
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || !tone_on_reg) begin
         low_div_reg <= 16'h0;
         high_div_reg <= 16'h0;
         low_phase_reg <= 5'h00;
         high_phase_reg <= 5'h00;
      end else begin
         if (low_div_reg >= seg_div({1'b0, tx_rowcol[3:2]}) - 16'h1) begin
            low_div_reg <= 16'h0;
            low_phase_reg <= low_phase_reg + 5'h01;
         end else begin
            low_div_reg <= low_div_reg + 16'h1;
         end
         if (high_div_reg >= seg_div({1'b1, tx_rowcol[1:0]}) - 16'h1) begin
            high_div_reg <= 16'h0;
            high_phase_reg <= high_phase_reg + 5'h01;
         end else begin
            high_div_reg <= high_div_reg + 16'h1;
         end
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;
   assign early_detect_out_o = early_reg;
   assign steer_guard_pin_o = steer_reg;
   assign interrupt_tone_pin_o = 1'b0;
   assign interrupt_tone_pin_oe_o = irq_oe_reg;
   assign tone_on_o = tone_on_reg;
   assign low_phase_o = low_phase_reg;
   assign high_phase_o = high_phase_reg;
   assign ctrl_second_o = ctrl_second_reg;

endmodule // dthr_regs

//--- dthr_regs_monitor.sv
// checker for the dual-tone host register block, bound to its ports
// assumes its guard parameters follow those of the bound instance
`timescale 1ns/1ns
module dthr_regs_monitor
   import dthr_pkg::*;
#(
   parameter int unsigned GUARD_PRESENT = GUARD_PRESENT_CYC,
   parameter int unsigned GUARD_ABSENT = GUARD_ABSENT_CYC
) (
   input wire logic clk_i,                   // clock
   input wire logic sys_rst_i,               // reset
   input wire logic s_axi_awvalid,           // aw valid
   input wire logic s_axi_awready,           // aw ready
   input wire logic [3:0] s_axi_araddr,      // read address
   input wire logic s_axi_arvalid,           // ar valid
   input wire logic s_axi_arready,           // ar ready
   input wire logic [31:0] s_axi_rdata,      // read data
   input wire logic [1:0] s_axi_rresp,       // read response
   input wire logic s_axi_rvalid,            // r valid
   input wire logic tone_present_i,          // detector presence
   input wire logic early_detect_out_o,      // early detect
   input wire logic steer_guard_pin_o,       // steering level
   input wire logic interrupt_tone_pin_o,    // pin value
   input wire logic interrupt_tone_pin_oe_o  // pin enable
);
   logic [15:0] hi_run;
   logic [15:0] lo_run;
   logic [3:0] ra;
   logic tk;
   // any request taken on the bus
   assign tk = (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);
   // saturating run lengths of detector presence and absence
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         hi_run <= 16'h0;
         lo_run <= 16'h0;
      end else begin
         hi_run <= tone_present_i ? hi_run + 16'(hi_run != 16'hFFFF) : 16'h0;
         lo_run <= !tone_present_i ? lo_run + 16'(lo_run != 16'hFFFF) : 16'h0;
      end
   end
   // address of the read under way
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) ra <= 4'h0;
      else if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   property p_pin_low; interrupt_tone_pin_o == 1'b0; endproperty
   a_pin_low: assert property (p_pin_low)
      else $error("interrupt pin drives high");
   property p_early; early_detect_out_o |-> $past(tone_present_i); endproperty
   a_early: assert property (p_early)
      else $error("early detect without tone");
   property p_steer_min; $rose(steer_guard_pin_o) |-> hi_run >= GUARD_PRESENT; endproperty
   a_steer_min: assert property (p_steer_min)
      else $error("steering set by a short burst");
   property p_steer_due; hi_run == GUARD_PRESENT + 2 |-> steer_guard_pin_o; endproperty
   a_steer_due: assert property (p_steer_due)
      else $error("steering missing after a valid tone");
   property p_steer_hold; $fell(steer_guard_pin_o) |-> lo_run >= GUARD_ABSENT; endproperty
   a_steer_hold: assert property (p_steer_hold)
      else $error("steering ended by a short dropout");
   property p_steer_end; lo_run == GUARD_ABSENT + 2 |-> !steer_guard_pin_o; endproperty
   a_steer_end: assert property (p_steer_end)
      else $error("steering kept after valid absence");
   property p_b3;
      $rose(s_axi_rvalid) && ra == 4'h4 |->
         s_axi_rdata[3] == !$past(steer_guard_pin_o) && s_axi_rdata[31:4] == 28'h0;
   endproperty
   a_b3: assert property (p_b3)
      else $error("status b3 disagrees with steering");
   property p_unmapped;
      $rose(s_axi_rvalid) && ra != 4'h0 && ra != 4'h4 |->
         s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not refused");
   property p_oe_fall;
      $fell(interrupt_tone_pin_oe_o) |-> $past(tk, 2) || $past(tk, 3) || $past(tk, 4);
   endproperty
   a_oe_fall: assert property (p_oe_fall)
      else $error("interrupt released without a bus access");
   c_steer: cover property ($rose(steer_guard_pin_o));
   c_oe: cover property ($fell(interrupt_tone_pin_oe_o));
   c_unmap: cover property ($rose(s_axi_rvalid) && ra == 4'h8);
endmodule // dthr_regs_monitor

bind dthr_regs dthr_regs_monitor #(.GUARD_PRESENT(GUARD_PRESENT), .GUARD_ABSENT(GUARD_ABSENT)) mon_u (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .tone_present_i(tone_present_i),
   .early_detect_out_o(early_detect_out_o), .steer_guard_pin_o(steer_guard_pin_o),
   .interrupt_tone_pin_o(interrupt_tone_pin_o),
   .interrupt_tone_pin_oe_o(interrupt_tone_pin_oe_o));

//--- dthr_tone_src.sv
// tone detector model feeding the receiver side of the register block
// assumes play is called just after a rising edge of clk_i
`timescale 1ns/1ns
module dthr_tone_src (
   input wire logic clk_i,     // system clock
   output logic present_o,     // tone presence level
   output logic [3:0] code_o,  // code of the pair present
   output logic cp_o           // call progress square wave, idle
);
   initial begin
      present_o = 1'b0;
      code_o = 4'hF;
      cp_o = 1'b0;
   end
   // tone for hi cycles, then absence for lo cycles
   task automatic play(input logic [3:0] c, input int hi, input int lo);
      present_o <= 1'b1;
      code_o <= c;
      repeat (hi) @(posedge clk_i);
      present_o <= 1'b0;
      code_o <= ~c; // code is not held once the tone is gone
      repeat (lo) @(posedge clk_i);
   endtask
   // call progress level
   task automatic set_cp(input logic v);
      cp_o <= v;
   endtask
endmodule // dthr_tone_src

//--- dthr_tb.sv
// self-checking bench for the dual-tone host register block
// assumes shortened guard and burst counts set at the instance
`timescale 1ns/1ns
module tb;
   import dthr_pkg::*;
   localparam int unsigned GP = 8;
   localparam int unsigned GA = 8;
   localparam int unsigned BL = 20;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF, code, ctl2;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
   logic awready, wready, bvalid, arready, rvalid, pres, cp, edet, steer, pin, oe, ton;
   logic [1:0] bresp, rresp, r;
   logic [4:0] lph, hph;
   int mismatches = 0, n_tests = 0, cyc = 0;
   wire irq_line = oe ? pin : 1'b1; // pull-up on the open-drain line
   always #50 clk_i = ~clk_i;
   dthr_regs #(.GUARD_PRESENT(GP), .GUARD_ABSENT(GA), .BURST_LEN(BL)) dut_u (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .tone_present_i(pres), .tone_code_i(code), .call_prog_i(cp), .early_detect_out_o(edet),
      .steer_guard_pin_o(steer), .interrupt_tone_pin_o(pin), .interrupt_tone_pin_oe_o(oe),
      .tone_on_o(ton), .low_phase_o(lph), .high_phase_o(hph), .ctrl_second_o(ctl2));
   dthr_tone_src src_u (.clk_i(clk_i), .present_o(pres), .code_o(code), .cp_o(cp));
   // one comparison
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // bus write, address and data offered together
   task automatic wr(input logic [3:0] a, input logic [3:0] v, output logic [1:0] rs);
      awaddr <= a;
      wdata <= {28'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clk_i);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      rs = bresp;
   endtask
   // bus read
   task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clk_i);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      v = rdata;
      rs = rresp;
   endtask
   // accesses expected to succeed
   task automatic w(input logic [3:0] a, input logic [3:0] v);
      wr(a, v, r);
      chk("bresp", 32'(RESP_OKAY), 32'(r));
   endtask
   task automatic rk(input logic [3:0] a);
      rd(a, d, r);
      chk("rresp", 32'(RESP_OKAY), 32'(r));
   endtask
   // software reset sequence and idle register values
   task automatic t_init();
      w(CTRL_OFFS, 4'h0);
      w(CTRL_OFFS, 4'h8);
      w(CTRL_OFFS, 4'h0);
      chk("ctrl second", 32'(CTRL_RST), 32'(ctl2));
      rk(DATA_OFFS);
      chk("rx data", 32'(CODE_RST), d);
      rk(CTRL_OFFS);
      chk("status", 32'h8, d & 32'hD);
      $display("t_init done");
   endtask
   // burst too short to be valid
   task automatic t_short();
      src_u.play(4'h3, GP - 3, GA + 2);
      chk("steer", 32'h0, 32'(steer));
      rk(CTRL_OFFS);
      chk("status", 32'h8, d & 32'hD);
      rk(DATA_OFFS);
      chk("rx data", 32'(CODE_RST), d);
      $display("t_short done");
   endtask
   // valid tone with interrupt, cleared by one status read
   task automatic t_valid();
      w(CTRL_OFFS, 4'h4);
      src_u.play(4'h5, GP + 4, 0);
      chk("steer", 32'h1, 32'(steer));
      chk("irq line", 32'h0, 32'(irq_line));
      rk(CTRL_OFFS);
      chk("status", 32'h5, d & 32'hD);
      repeat (3) @(posedge clk_i);
      chk("irq enable", 32'h0, 32'(oe));
      rk(CTRL_OFFS);
      chk("status", 32'h0, d & 32'h5);
      repeat (GA + 4) @(posedge clk_i);
      chk("steer", 32'h0, 32'(steer));
      rk(DATA_OFFS);
      chk("rx data", 32'h5, d);
      $display("t_valid done");
   endtask
   // short dropout inside a tone, then a valid end
   task automatic t_drop();
      src_u.play(4'h7, GP + 4, GA - 3);
      chk("steer", 32'h1, 32'(steer));
      src_u.play(4'h7, 2, GA + 4);
      chk("steer", 32'h0, 32'(steer));
      rk(DATA_OFFS);
      chk("rx data", 32'h7, d);
      $display("t_drop done");
   endtask
   // transmit write, shared control address, burst ready interrupt
   task automatic t_tx();
      w(DATA_OFFS, 4'h9);
      rk(DATA_OFFS);
      chk("rx data", 32'h7, d);
      w(CTRL_OFFS, 4'h8);
      w(CTRL_OFFS, 4'h1);
      chk("ctrl second", 32'h1, 32'(ctl2));
      w(CTRL_OFFS, 4'h4);
      chk("ctrl second", 32'h1, 32'(ctl2));
      rk(CTRL_OFFS);
      w(DATA_OFFS, 4'h2);
      repeat (BL) @(posedge clk_i);
      chk("irq enable", 32'h0, 32'(oe));
      repeat (BL + 10) @(posedge clk_i);
      chk("irq line", 32'h0, 32'(irq_line));
      w(CTRL_OFFS, 4'h0);
      repeat (2) @(posedge clk_i);
      chk("irq enable", 32'h0, 32'(oe));
      rk(CTRL_OFFS);
      chk("status", 32'h2, d & 32'h2);
      $display("t_tx done");
   endtask
   // unmapped offset refused both ways
   task automatic t_unmap();
      wr(4'h8, 4'h3, r);
      chk("bresp", 32'(RESP_SLVERR), 32'(r));
      rd(4'h8, d, r);
      chk("rresp", 32'(RESP_SLVERR), 32'(r));
      chk("rdata", 32'h0, d);
      chk("ctrl second", 32'h1, 32'(ctl2));
      $display("t_unmap done");
   endtask
   // segment periods for code 0
   task automatic t_gen();
      int nh = 0, nl = 0;
      w(CTRL_OFFS, 4'h9);
      w(CTRL_OFFS, 4'h0);
      w(DATA_OFFS, 4'h0);
      while (lph != 5'h02) begin
         @(posedge clk_i);
         nh += int'(hph == 5'h01);
         nl += int'(lph == 5'h01);
      end
      chk("high seg", 32'hBE, nh);
      chk("low seg", 32'h14A, nl);
      $display("t_gen done");
   endtask
   // call progress mode
   task automatic t_cp();
      src_u.set_cp(1'b1);
      w(CTRL_OFFS, 4'h6);
      repeat (2) @(posedge clk_i);
      chk("irq enable", 32'h0, 32'(oe));
      src_u.set_cp(1'b0);
      repeat (2) @(posedge clk_i);
      chk("irq line", 32'h0, 32'(irq_line));
      $display("t_cp done");
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // hang guard
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         wrap_up();
      end
   end
   initial begin
      repeat (3) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      t_init();
      t_short();
      t_valid();
      t_drop();
      t_tx();
      t_unmap();
      t_gen();
      t_cp();
      wrap_up();
   end
endmodule // tb
